// >>> rtl/rgd_defs.vh
`ifndef RGD_DEFS_VH
`define RGD_DEFS_VH
// Register byte addresses
`define RGD_ADDR_CONTROL 16'hFE79
`define RGD_ADDR_IRQ_STATUS 16'hFE7A
`define RGD_ADDR_IRQ_MASK 16'hFE7B
// Control register field positions
`define RGD_BIT_FLAG 7
`define RGD_BIT_CKSEL 6
`define RGD_BIT_RUN 5
`define RGD_BIT_STBY_HI 4
`define RGD_BIT_STBY_LO 3
`define RGD_SEL_HI 2
`define RGD_SEL_LO 0
// Reset values
`define RGD_CONTROL_RESET 8'h00
`define RGD_IRQ_RESET 8'h00
// Counter-clear key value
`define RGD_CLEAR_KEY 8'h55
// Standby action codes
`define RGD_STBY_CONT0 2'h0
`define RGD_STBY_STOP 2'h1
`define RGD_STBY_HOLDCNT 2'h2
`define RGD_STBY_CONT3 2'h3
// Threshold base: code 0 gives 2^10 counts
`define RGD_THRESH_BASE_LOG2 10
// Interrupt status bit positions
`define RGD_IRQ_OVF 0
`define RGD_IRQ_SUBSTOP 1
`endif

// >>> rtl/rgd_runaway_guard.v
// How it works
// - Counter is 17 bits, incrementing per selected slow-clock tick while running.
// - Bit 6 picks RC oscillator clock at 0, subclock at 1.
// - Overflow when count equals threshold chosen by bits 2..0.
// - Codes 000..111 give 1024 up to 131072 counts, doubling each step.
// - Overflow raises guard reset, clears run, sets flag bit 7.
// - Running on subclock: subclock stop or HOLD entry causes guard reset.
// - Bits 4..3: 00/11 continue, 01 stop, 10 halt keeping count.
// - Pin/POR/LOW_VOLTAGE_DETECTOR reset clears all; guard reset keeps bits 6 and 4..0.
// - While running, ordinary writes ignored; register stays readable.
// - Dedicated immediate move of 55H while running clears counter.
// - 55H by other instructions does not clear; CPU flags the instruction.
// - Flag cleared by pin/POR/LOW_VOLTAGE_DETECTOR reset, set by guard reset, software writable.
// - Run bit 1 counts, 0 stops and holds the counter at zero.
// - RC oscillator enabled when clock select is 0 and run is 1.
// - Only external resets, an overflow or subclock-loss trip, or standby with action 01 stop a running guard.
// - RC-clocked counting continues even when the system clock stops.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "rgd_defs.vh"
module rgd_runaway_guard #(
    parameter CNT_W = 17
) (
    input wire clk,
    input wire nrst,
    input wire [15:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire wr_is_clear_move,
    output reg [7:0] rdata,
    input wire rc_tick_raw,
    input wire sub_tick_raw,
    input wire subclock_osc_enable,
    input wire standby_enter,
    input wire standby_active,
    input wire hold_enter,
    output wire rc_osc_enable,
    output reg guard_reset,
    output wire irq
);
    // Control register and fields
    reg [7:0] guard_control_reg;
    reg [CNT_W-1:0] guard_counter;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    // Tick synchronisers and edge memory
    reg rc_s1;
    reg rc_s2;
    reg rc_s3;
    reg sub_s1;
    reg sub_s2;
    reg sub_s3;
    wire guard_run;
    wire guard_clock_select;
    wire [1:0] standby_action;
    wire [2:0] overflow_select;
    wire tick;
    wire counting;
    wire overflow;
    wire sub_stop;
    wire trip;
    wire ctl_hit;
    wire clear_op;
    wire stop_by_standby;
    wire [7:0] irq_event;
    wire [7:0] irq_clear;
    genvar gi;

    // Last count before the threshold; the top code needs one bit more than the counter
    function [CNT_W-1:0] thresh;
        input [2:0] code;
        reg [CNT_W:0] full;
        begin
            full = {{CNT_W{1'b0}}, 1'b1} << (`RGD_THRESH_BASE_LOG2 + code);
            thresh = full[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Register address decode for the write paths; the read path uses a case on addr
    function hit;
        input [15:0] a;
        input [15:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Field decode
    assign guard_run = guard_control_reg[`RGD_BIT_RUN];
    assign guard_clock_select = guard_control_reg[`RGD_BIT_CKSEL];
    assign standby_action = guard_control_reg[`RGD_BIT_STBY_HI:`RGD_BIT_STBY_LO];
    assign overflow_select = guard_control_reg[`RGD_SEL_HI:`RGD_SEL_LO];
    assign ctl_hit = hit(addr, `RGD_ADDR_CONTROL);

    // RC oscillator request
    assign rc_osc_enable = guard_run & ~guard_clock_select;

    // Bring slow-clock ticks in through two flops, then edge detect
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end
        else
        begin
            rc_s1 <= rc_tick_raw;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
            sub_s1 <= sub_tick_raw;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    // Selected slow tick; RC path does not depend on the CPU running
    assign tick = guard_clock_select ? (sub_s2 & ~sub_s3) : (rc_s2 & ~rc_s3);

    // Standby action decide whether counting pauses
    assign counting = guard_run & tick &
        ~(standby_active & (standby_action == `RGD_STBY_HOLDCNT));

    // Overflow and subclock-loss trip
    // Tick that would reach the threshold trips, so the 17-bit count never wraps
    assign overflow = counting & (guard_counter == thresh(overflow_select));
    assign sub_stop = guard_run & guard_clock_select &
        (~subclock_osc_enable | hold_enter);
    assign trip = overflow | sub_stop;
    assign stop_by_standby = guard_run & standby_enter &
        (standby_action == `RGD_STBY_STOP);

    // Clear only by the dedicated move carrying the key while running
    assign clear_op = wr & ctl_hit & guard_run & wr_is_clear_move &
        (wdata == `RGD_CLEAR_KEY);

    // Counter
    always @(posedge clk)
    begin
        if (!nrst)
            guard_counter <= {CNT_W{1'b0}};
        else if (!guard_run || trip || stop_by_standby || clear_op)
            guard_counter <= {CNT_W{1'b0}};
        else if (counting)
            guard_counter <= guard_counter + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // Control register; nrst stands for pin, POR and LOW_VOLTAGE_DETECTOR resets
    always @(posedge clk)
    begin
        if (!nrst)
            guard_control_reg <= `RGD_CONTROL_RESET;
        else if (trip)
        begin
            guard_control_reg[`RGD_BIT_FLAG] <= 1'b1;
            guard_control_reg[`RGD_BIT_RUN] <= 1'b0;
        end
        else if (stop_by_standby)
            guard_control_reg[`RGD_BIT_RUN] <= 1'b0;
        else if (wr && ctl_hit && !guard_run)
            guard_control_reg <= wdata;
    end

    // Guard reset pulse for the rest of the chip
    always @(posedge clk)
    begin
        if (!nrst)
            guard_reset <= 1'b0;
        else
            guard_reset <= trip;
    end

    // Status events and write-one clear mask
    assign irq_event = {6'h00, sub_stop, overflow};
    assign irq_clear = (wr && hit(addr, `RGD_ADDR_IRQ_STATUS)) ? wdata : 8'h00;

    // Sticky status bits: set beats write-one clear
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_status
            always @(posedge clk)
            begin
                if (!nrst)
                    irq_status[gi] <= 1'b0;
                else if (irq_event[gi])
                    irq_status[gi] <= 1'b1;
                else if (irq_clear[gi])
                    irq_status[gi] <= 1'b0;
            end
        end
    endgenerate

    // Interrupt mask register
    always @(posedge clk)
    begin
        if (!nrst)
            irq_mask <= `RGD_IRQ_RESET;
        else if (wr && hit(addr, `RGD_ADDR_IRQ_MASK))
            irq_mask <= wdata;
    end
    assign irq = |(irq_status & irq_mask);

    // Read port, data one cycle after strobe
    always @(posedge clk)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `RGD_ADDR_CONTROL: rdata <= guard_control_reg;
                `RGD_ADDR_IRQ_STATUS: rdata <= irq_status;
                `RGD_ADDR_IRQ_MASK: rdata <= irq_mask;
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule

// >>> tb/rgd_guard_checker.sv
`timescale 1ns/1ps
module rgd_guard_checker (
    input wire clk, nrst, wr, rd, wr_is_clear_move, rc_tick_raw, sub_tick_raw,
    input wire subclock_osc_enable, standby_enter, standby_active, hold_enter,
    input wire rc_osc_enable, guard_reset, irq,
    input wire [15:0] addr,
    input wire [7:0] wdata, rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Clear move seen while running
    sequence s_clear;
        rc_osc_enable && wr && wr_is_clear_move && wdata == 8'h55;
    endsequence
    // Port relations
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !guard_reset && !rc_osc_enable
        && !irq && rdata == 8'h00) else $error("busy after reset");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("stray read data");
    a_trip_pulse: assert property (guard_reset |=> !guard_reset) else $error("long trip");
    a_trip_stops: assert property (guard_reset |-> !rc_osc_enable) else $error("run kept");
    a_rc_start: assert property ($rose(rc_osc_enable) |-> $past(wr && addr == 16'hFE79
        && wdata[6:5] == 2'b01)) else $error("osc start w/o write");
    a_no_sw_stop: assert property (rc_osc_enable && !standby_enter |=> rc_osc_enable
        || guard_reset) else $error("guard stopped");
    a_clear_no_trip: assert property (s_clear |=> ##1 !guard_reset [*4])
        else $error("trip after clear");
    a_rd_run: assert property (rd && addr == 16'hFE79 && rc_osc_enable |=> rdata[6:5] == 2'b01)
        else $error("run bits unread");
endmodule
bind rgd_runaway_guard rgd_guard_checker chk_u (.*);

// >>> tb/rgd_runaway_guard_tb.sv
`timescale 1ns/1ps
`include "rgd_defs.vh"
module rgd_runaway_guard_tb;
    localparam C = `RGD_ADDR_CONTROL;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, wr_is_clear_move = 0, rc_tick_raw = 0;
    logic sub_tick_raw = 0, subclock_osc_enable = 1, standby_enter = 0, standby_active = 0;
    logic hold_enter = 0;
    logic [15:0] addr = 0;
    logic [7:0] wdata = 0, cfg, trips = 0;
    wire [7:0] rdata;
    wire rc_osc_enable, guard_reset, irq;
    int error_cnt = 0, n_compared = 0, seed = 33532, t;
    rgd_runaway_guard dut_u (.*);
    // Clock and trip counter
    always #4 clk = ~clk;
    always @(posedge clk)
        if (guard_reset === 1'b1) trips <= trips + 8'h01;
    task chk(input [7:0] got, input [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wrt(input [15:0] a, input [7:0] d, input m);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1; wr_is_clear_move <= m;
        @(posedge clk);
        wr <= 0; wr_is_clear_move <= 0; #1;
    endtask
    task rdc(input [15:0] a, input [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1;
        @(posedge clk);
        rd <= 0; #1;
        chk(rdata, e);
    endtask
    // Slow clock ticks, two cycles high and two low
    task tk(input int n);
        repeat (n)
        begin
            @(posedge clk) rc_tick_raw <= 1;
            repeat (2) @(posedge clk);
            rc_tick_raw <= 0;
            @(posedge clk);
        end
        cyc(3);
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #600000;
        error_cnt++;
        conclude;
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1;
        rdc(C, 8'h00);
        rdc(16'hFE00, 8'h00);
        t = $random(seed) & 1;
        cfg = 8'h30 | t[7:0];
        wrt(C, cfg & 8'hDF, 0);
        wrt(C, cfg, 0);
        chk(rc_osc_enable, 1);
        wrt(C, 8'h00, 0);
        rdc(C, cfg);
        tk((1024 << t) - 9);
        wrt(C, 8'h55, 0);
        tk(8);
        chk(trips, 0);
        tk(1);
        chk(trips, 1);
        rdc(C, 8'h80 | (cfg & 8'h5F));
        chk(irq, 0);
        wrt(16'hFE7B, 8'h01, 0);
        chk(irq, 1);
        wrt(16'hFE7A, 8'h01, 0);
        chk(irq, 0);
        $display("overflow test done");
        wrt(C, 8'h20, 0);
        tk(1000);
        wrt(C, 8'h55, 1);
        tk(1023);
        chk(trips, 1);
        tk(1);
        rdc(C, 8'h80);
        wrt(C, 8'h60, 0);
        subclock_osc_enable <= 0;
        cyc(3);
        chk(trips, 3);
        subclock_osc_enable <= 1;
        wrt(C, 8'h60, 0);
        hold_enter <= 1;
        cyc(1);
        hold_enter <= 0;
        cyc(2);
        chk(trips, 4);
        wrt(C, 8'h30, 0);
        standby_active <= 1;
        tk(1030);
        standby_active <= 0;
        chk(trips, 4);
        tk(1024);
        chk(trips, 5);
        $display("subclock and standby tests done");
        wrt(C, 8'h28, 0);
        standby_enter <= 1;
        cyc(1);
        standby_enter <= 0;
        cyc(1);
        chk(rc_osc_enable, 0);
        nrst <= 0;
        cyc(2);
        nrst <= 1;
        rdc(C, 8'h00);
        $display("tests done");
        conclude;
    end
endmodule
